//--- hdl/serial_line_auto_powerdown.v
// dual line transceiver power control with inactivity powerdown and AXI4-Lite registers
//
// Summary of operation
// - supply above 2.9 V: charge pump runs as doubler, third capacitor ignored.
// - supply below 2.1 V: charge pump runs as tripler with three capacitors.
// - each transmit path inverts its logic input while powered.
// - each receive output is inverted line input; high impedance while shutdown is low.
// - receive paths keep working during inactivity powerdown.
// - an open receive line reads low, so its logic output is high.
// - auto powerdown enabled only with keep-awake low and shutdown high.
// - 30 s without any input edge stops pump and floats line outputs.
// - any input edge while asleep restarts pump, outputs and timer.
// - outputs valid 30 us after waking edge, never beyond 150 us.
// - shutdown low powers off both directions regardless of anything else.
// - keep-awake and shutdown high keep everything active, no powerdown.
// - line status high while any receive line is driven, low when all open.
// - inactivity interval lies between 15 s and 60 s, 30 s typical.
// - line status rises about 1 us after drive, falls 30 us after open.
`timescale 1ns/1ps
`default_nettype none
`include "line_pd_regs.vh"
module serial_line_auto_powerdown #(
  parameter integer NCH        = 2,
  parameter [35:0]  IDLE_CYC   = `IDLE_CYC_DEF,
  parameter integer WAKE_CYC   = `US_CYC(`WAKE_US),
  parameter integer VALID_CYC  = `US_CYC(`VALID_US),
  parameter integer INVAL_CYC  = `US_CYC(`INVALID_US)
) (
  // clock and reset
  input  wire            clk,
  input  wire            rst,
  // logic side
  input  wire [NCH-1:0]  txIn,
  output reg  [NCH-1:0]  logic_rx_out,
  output reg  [NCH-1:0]  logicRxOe,
  output reg             lineValid,
  // line side
  output reg  [NCH-1:0]  lineTxOut,
  output reg  [NCH-1:0]  lineTxOe,
  input  wire [NCH-1:0]  line_rx_in,
  input  wire [NCH-1:0]  lineRxDriven,
  // mode pins and supply sense
  input  wire            keep_awake_in,
  input  wire            shutdown_n_in,
  input  wire [11:0]     supplyMv,
  output reg             pumpOn,
  output reg             pumpTripler,
  // interrupt
  output reg             irq,
  // axi4-lite slave
  input  wire [3:0]      s_axi_awaddr,
  input  wire            s_axi_awvalid,
  output reg             s_axi_awready,
  input  wire [31:0]     s_axi_wdata,
  input  wire [3:0]      s_axi_wstrb,
  input  wire            s_axi_wvalid,
  output reg             s_axi_wready,
  output reg  [1:0]      s_axi_bresp,
  output reg             s_axi_bvalid,
  input  wire            s_axi_bready,
  input  wire [3:0]      s_axi_araddr,
  input  wire            s_axi_arvalid,
  output reg             s_axi_arready,
  output reg  [31:0]     s_axi_rdata,
  output reg  [1:0]      s_axi_rresp,
  output reg             s_axi_rvalid,
  input  wire            s_axi_rready
);

  localparam [1:0] ST_OFF   = 2'h0;
  localparam [1:0] ST_WAKE  = 2'h1;
  localparam [1:0] ST_ON    = 2'h2;
  localparam [1:0] ST_SLEEP = 2'h3;

  reg  [1:0]            state_r;
  reg  [1:0]            state_nxt;
  reg  [35:0]           idleCnt_r;
  reg  [31:0]           wakeCnt_r;
  reg  [31:0]           validCnt_r;
  reg  [NCH-1:0]        txPrev_r;
  reg  [NCH-1:0]        rxPrev_r;
  reg  [1:0]            ctrl_r;
  reg  [`EV_WIDTH-1:0]  evStat_r;
  reg  [`EV_WIDTH-1:0]  evMask_r;
  reg  [`EV_WIDTH-1:0]  evSet;
  reg  [3:0]            awAddr_r;
  reg  [31:0]           wData_r;
  reg                   awHave_r;
  reg                   wHave_r;
  reg                   wStrb0_r;

  // pin and register controls combine: either may force shutdown or keep-awake
  wire keepAwake = keep_awake_in | ctrl_r[`CTRL_KEEP_AWAKE];
  wire shutN     = shutdown_n_in & ctrl_r[`CTRL_SHUTDOWN_N];
  wire autoEn    = ~keepAwake & shutN;
  wire anyEdge   = |((txIn ^ txPrev_r) | (line_rx_in ^ rxPrev_r));
  wire anyDriven = |lineRxDriven;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      txPrev_r <= {NCH{1'b0}};
      rxPrev_r <= {NCH{1'b0}};
    end else begin
      txPrev_r <= txIn;
      rxPrev_r <= line_rx_in;
    end
  end

  // inactivity counter
  // 36 bits wide: the default interval overflows a 32-bit count
  always @(posedge clk or posedge rst) begin
    if (rst)
      idleCnt_r <= 36'h0;
    else if (!autoEn || anyEdge || state_r != ST_ON)
      idleCnt_r <= 36'h0;
    else if (idleCnt_r < IDLE_CYC)
      idleCnt_r <= idleCnt_r + 36'h1;
  end

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_OFF:   if (shutN) state_nxt = ST_WAKE;
      ST_WAKE:  if (wakeCnt_r >= WAKE_CYC - 1) state_nxt = ST_ON;
      ST_ON:    if (autoEn && idleCnt_r >= IDLE_CYC - 1 && !anyEdge) state_nxt = ST_SLEEP;
      ST_SLEEP: if (anyEdge || !autoEn) state_nxt = ST_WAKE;
      default:  state_nxt = ST_OFF;
    endcase
    if (!shutN)
      state_nxt = ST_OFF;
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r   <= ST_OFF;
      wakeCnt_r <= 32'h0;
    end else begin
      state_r   <= state_nxt;
      wakeCnt_r <= (state_r == ST_WAKE) ? wakeCnt_r + 32'h1 : 32'h0;
    end
  end

  // line status filter: short rise, long fall so brief gaps do not report open
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      validCnt_r <= 32'h0;
      lineValid  <= 1'b0;
    end else if (anyDriven == lineValid) begin
      validCnt_r <= 32'h0;
    end else if (validCnt_r >= (anyDriven ? VALID_CYC : INVAL_CYC) - 1) begin
      validCnt_r <= 32'h0;
      lineValid  <= anyDriven;
    end else begin
      validCnt_r <= validCnt_r + 32'h1;
    end
  end

  // per-channel data paths
  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch = ch + 1) begin : g_chan
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          lineTxOut[ch]    <= 1'b0;
          lineTxOe[ch]     <= 1'b0;
          logic_rx_out[ch] <= 1'b0;
          logicRxOe[ch]    <= 1'b0;
        end else begin
          lineTxOut[ch]    <= ~txIn[ch];
          lineTxOe[ch]     <= (state_nxt == ST_ON);
          // undriven line is pulled low and so reads as logic high
          logic_rx_out[ch] <= ~(line_rx_in[ch] & lineRxDriven[ch]);
          // receive side ignores sleep, only shutdown disables it
          logicRxOe[ch]    <= shutN;
        end
      end
    end
  endgenerate

  // charge pump control
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pumpOn      <= 1'b0;
      pumpTripler <= 1'b0;
    end else begin
      pumpOn      <= (state_nxt == ST_WAKE) || (state_nxt == ST_ON);
      // between thresholds the previous mode holds as hysteresis
      if (supplyMv > `VDBL_MV)
        pumpTripler <= 1'b0;
      else if (supplyMv < `VTRI_MV)
        pumpTripler <= 1'b1;
    end
  end

  // events
  always @* begin
    evSet = {`EV_WIDTH{1'b0}};
    evSet[`EV_SLEEP]     = (state_r == ST_ON) && (state_nxt == ST_SLEEP);
    evSet[`EV_WAKE]      = (state_r == ST_SLEEP) && (state_nxt == ST_WAKE);
    evSet[`EV_VALID_CHG] = (anyDriven != lineValid) &&
                           (validCnt_r >= (anyDriven ? VALID_CYC : INVAL_CYC) - 1);
  end

  // the write lands one cycle after both halves are held, never while a response waits
  wire wrFire = awHave_r && wHave_r && !s_axi_bvalid;
  wire [`EV_WIDTH-1:0] w1c = (wrFire && awAddr_r == `REG_IRQ_STAT && wStrb0_r) ?
                             wData_r[`EV_WIDTH-1:0] : {`EV_WIDTH{1'b0}};

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      evStat_r <= {`EV_WIDTH{1'b0}};
      irq      <= 1'b0;
    end else begin
      // a new event wins over a simultaneous clear
      evStat_r <= (evStat_r & ~w1c) | evSet;
      irq      <= |(((evStat_r & ~w1c) | evSet) & evMask_r);
    end
  end

  // axi4-lite write: address and data may arrive in either order
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      awHave_r      <= 1'b0;
      wHave_r       <= 1'b0;
      awAddr_r      <= 4'h0;
      wData_r       <= 32'h0;
      wStrb0_r      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      ctrl_r        <= `CTRL_RST_VAL;
      evMask_r      <= {`EV_WIDTH{1'b0}};
    end else begin
      s_axi_awready <= !awHave_r && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= !wHave_r && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        awHave_r <= 1'b1;
        awAddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHave_r <= 1'b1;
        wData_r <= s_axi_wdata;
        // strobe kept with the data: the master may change it once wvalid is taken
        wStrb0_r <= s_axi_wstrb[0];
      end
      if (wrFire) begin
        awHave_r     <= 1'b0;
        wHave_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= `RESP_OKAY;
        case (awAddr_r)
          `REG_CTRL:     if (wStrb0_r) ctrl_r <= wData_r[1:0];
          `REG_IRQ_MASK: if (wStrb0_r) evMask_r <= wData_r[`EV_WIDTH-1:0];
          `REG_IRQ_STAT: ;
          `REG_STATUS:   ;
          default:       s_axi_bresp <= `RESP_SLVERR;
        endcase
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // axi4-lite read
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && !s_axi_arvalid ? 1'b0 :
                       (!s_axi_arready && !s_axi_rvalid);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `RESP_OKAY;
        s_axi_rdata  <= 32'h0;
        case (s_axi_araddr)
          `REG_CTRL:     s_axi_rdata[1:0] <= ctrl_r;
          `REG_STATUS: begin
            s_axi_rdata[`ST_POWERED]    <= lineTxOe[0];
            s_axi_rdata[`ST_LINE_VALID] <= lineValid;
            s_axi_rdata[`ST_TRIPLER]    <= pumpTripler;
            s_axi_rdata[`ST_DOUBLER]    <= ~pumpTripler;
          end
          `REG_IRQ_STAT: s_axi_rdata[`EV_WIDTH-1:0] <= evStat_r;
          `REG_IRQ_MASK: s_axi_rdata[`EV_WIDTH-1:0] <= evMask_r;
          default:       s_axi_rresp <= `RESP_SLVERR;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // serial_line_auto_powerdown
`default_nettype wire

//--- common/line_pd_regs.vh
// register map, field positions and timing constants of the line powerdown controller
`ifndef LINE_PD_REGS_VH
`define LINE_PD_REGS_VH
`define CLK_MHZ          200
// register byte offsets
`define REG_CTRL         4'h0
`define REG_STATUS       4'h4
`define REG_IRQ_STAT     4'h8
`define REG_IRQ_MASK     4'hC
// control fields
`define CTRL_KEEP_AWAKE  0
`define CTRL_SHUTDOWN_N  1
`define CTRL_RST_VAL     2'h2
// status fields
`define ST_POWERED       0
`define ST_LINE_VALID    1
`define ST_TRIPLER       2
`define ST_DOUBLER       3
// event bits
`define EV_SLEEP         0
`define EV_WAKE          1
`define EV_VALID_CHG     2
`define EV_WIDTH         3
// supply code thresholds in millivolts
`define VDBL_MV          12'hB54
`define VTRI_MV          12'h834
// times
`define IDLE_S           30
// 30 s at 200 MHz does not fit 32 bits
`define IDLE_CYC_DEF     36'h165A0BC00
`define WAKE_US          30
`define VALID_US         1
`define INVALID_US       30
`define US_CYC(u)        ((u) * `CLK_MHZ)
// axi responses
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2
`endif

//--- bench/serial_line_auto_powerdown_sva.sv
// assertion checker of the line powerdown controller
`timescale 1ns/1ps
`default_nettype none
module serial_line_auto_powerdown_sva #(
  parameter integer VALID_CYC = 4,
  parameter integer INVAL_CYC = 8
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // data paths
  input wire logic [1:0]  txIn,
  input wire logic [1:0]  logic_rx_out,
  input wire logic [1:0]  logicRxOe,
  input wire logic        lineValid,
  input wire logic [1:0]  lineTxOut,
  input wire logic [1:0]  lineTxOe,
  input wire logic [1:0]  line_rx_in,
  input wire logic [1:0]  lineRxDriven,
  // modes and supply
  input wire logic        keep_awake_in,
  input wire logic        shutdown_n_in,
  input wire logic [11:0] supplyMv,
  input wire logic        pumpOn,
  input wire logic        pumpTripler
);
  int drvCnt;
  int openCnt;
  // run lengths of driven and all-open receive lines
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      drvCnt  <= 0;
      openCnt <= 0;
    end else begin
      drvCnt  <= (|lineRxDriven) ? drvCnt + 1 : 0;
      openCnt <= (|lineRxDriven) ? 0 : openCnt + 1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_txinv; lineTxOe[0] |-> lineTxOut == ~$past(txIn); endproperty
  a_txinv: assert property (p_txinv) else $error("transmit output not inverted");
  property p_rxinv; logicRxOe[0] |-> logic_rx_out == ~$past(line_rx_in & lineRxDriven); endproperty
  a_rxinv: assert property (p_rxinv) else $error("receive output not inverted");
  property p_rxoff; !shutdown_n_in |=> logicRxOe == 2'h0; endproperty
  a_rxoff: assert property (p_rxoff) else $error("receive output driven in shutdown");
  property p_pwroff; !shutdown_n_in |=> lineTxOe == 2'h0 && !pumpOn; endproperty
  a_pwroff: assert property (p_pwroff) else $error("drivers powered in shutdown");
  property p_dbl; supplyMv > 12'hB54 |=> !pumpTripler; endproperty
  a_dbl: assert property (p_dbl) else $error("pump not doubler at high supply");
  property p_tri; supplyMv < 12'h834 |=> pumpTripler; endproperty
  a_tri: assert property (p_tri) else $error("pump not tripler at low supply");
  property p_forced; keep_awake_in && shutdown_n_in && $past(keep_awake_in) |-> !$fell(lineTxOe[0]); endproperty
  a_forced: assert property (p_forced) else $error("drivers slept while forced on");
  property p_wake; $rose(pumpOn) |-> ##[1:40] (lineTxOe == 2'h3 || !shutdown_n_in); endproperty
  a_wake: assert property (p_wake) else $error("drivers late after wake");
  property p_vrise; $rose(lineValid) |-> drvCnt >= VALID_CYC; endproperty
  a_vrise: assert property (p_vrise) else $error("line status rose early");
  property p_vfall; $fell(lineValid) |-> openCnt >= INVAL_CYC; endproperty
  a_vfall: assert property (p_vfall) else $error("line status fell before filter");
endmodule // serial_line_auto_powerdown_sva
bind serial_line_auto_powerdown serial_line_auto_powerdown_sva #(.VALID_CYC(VALID_CYC), .INVAL_CYC(INVAL_CYC))
  i_serial_line_auto_powerdown_sva (.clk, .rst, .txIn, .logic_rx_out, .logicRxOe, .lineValid, .lineTxOut,
  .lineTxOe, .line_rx_in, .lineRxDriven, .keep_awake_in, .shutdown_n_in, .supplyMv, .pumpOn, .pumpTripler);
`default_nettype wire

//--- bench/line_partner.sv
// remote line equipment model driving the receive lines
`timescale 1ns/1ps
`default_nettype none
module line_partner (
  // clock
  input  wire logic       clk,
  // commands from the bench
  input  wire logic [1:0] attach,
  input  wire logic [1:0] level,
  input  wire logic       echo,
  // line side
  input  wire logic [1:0] lineTxOut,
  input  wire logic [1:0] lineTxOe,
  output var  logic [1:0] line_rx_in,
  output var  logic [1:0] lineRxDriven
);
  // answers one cycle late; echo loops back what it hears, released drivers read low
  always_ff @(posedge clk) begin
    lineRxDriven <= attach;
    line_rx_in   <= attach & (echo ? (lineTxOut & lineTxOe) : level);
  end
endmodule // line_partner
`default_nettype wire

//--- bench/serial_line_auto_powerdown_test.sv
// self-checking bench of the line powerdown controller
`timescale 1ns/1ps
`default_nettype none
module serial_line_auto_powerdown_test;
  logic        clk;
  logic        rst = 1'b1, keep_awake_in = 1'b0, shutdown_n_in = 1'b1, echo = 1'b0;
  logic [1:0]  txIn = 2'h0, attach = 2'h3, level = 2'h0;
  logic [11:0] supplyMv = 12'hCE4;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, logic_rx_out, logicRxOe, lineTxOut, lineTxOe, line_rx_in, lineRxDriven;
  logic [31:0] s_axi_rdata;
  logic        lineValid, pumpOn, pumpTripler, irq;
  int          failures = 0, cmp_count = 0, cyc = 0;
  // rows: txIn, level, attach, expected lineTxOut, expected logic_rx_out
  logic [9:0]  rows [4] = '{10'h03F, 10'h1B9, 10'h2D6, 10'h3C3};
  // supply rows: expected tripler flag above the sensed level
  logic [12:0] sup [5] = '{13'h1708, 13'h19C4, 13'h0B55, 13'h1833, 13'h1B54};
  serial_line_auto_powerdown #(.IDLE_CYC(100), .WAKE_CYC(8), .VALID_CYC(4), .INVAL_CYC(8))
    i_serial_line_auto_powerdown (.clk, .rst, .txIn, .logic_rx_out, .logicRxOe, .lineValid, .lineTxOut,
    .lineTxOe, .line_rx_in, .lineRxDriven, .keep_awake_in, .shutdown_n_in, .supplyMv, .pumpOn, .pumpTripler,
    .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  line_partner i_line_partner (.clk, .attach, .level, .echo, .lineTxOut, .lineTxOe, .line_rx_in, .lineRxDriven);
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task give_verdict;
    $display("comparisons %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // the whole run needs under 2000 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      failures++;
      give_verdict();
    end
  end
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task axw(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", s_axi_bresp, er);
    @(posedge clk);
  endtask
  task rchk(input logic [3:0] a, input logic [31:0] exp, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    chk("rdata", s_axi_rdata, exp);
    chk("rresp", s_axi_rresp, er);
    @(posedge clk);
  endtask
  initial begin
    tick(5);
    rst <= 1'b0;
    tick(12);
    rchk(4'h0, 32'h2, 2'h0);
    rchk(4'hC, 32'h0, 2'h0);
    rchk(4'h2, 32'h0, 2'h2);
    axw(4'h2, 32'h1, 2'h2);
    for (int i = 0; i < 4; i++) begin
      {txIn, level, attach} <= rows[i][9:4];
      tick(3);
      chk("lineTxOut", lineTxOut, rows[i][3:2]);
      chk("logic_rx_out", logic_rx_out, rows[i][1:0]);
    end
    chk("lineValid", lineValid, 1'b1);
    tick(12);
    chk("lineValid", lineValid, 1'b0);
    attach <= 2'h3;
    tick(3);
    chk("lineValid", lineValid, 1'b0);
    tick(8);
    chk("lineValid", lineValid, 1'b1);
    for (int i = 0; i < 5; i++) begin
      supplyMv <= sup[i][11:0];
      tick(3);
      chk("pumpTripler", pumpTripler, sup[i][12]);
    end
    rchk(4'h4, 32'h7, 2'h0);
    supplyMv <= 12'hCE4;
    echo <= 1'b1;
    txIn <= 2'h1;
    tick(4);
    chk("logic_rx_out", logic_rx_out, 2'h1);
    echo <= 1'b0;
    axw(4'hC, 32'h1, 2'h0);
    axw(4'h8, 32'h7, 2'h0);
    tick(40);
    chk("lineTxOe", lineTxOe, 2'h3);
    tick(170);
    chk("lineTxOe", lineTxOe, 2'h0);
    chk("pumpOn", pumpOn, 1'b0);
    chk("logicRxOe", logicRxOe, 2'h3);
    chk("irq", irq, 1'b1);
    level <= 2'h1;
    tick(3);
    chk("logic_rx_out", logic_rx_out, 2'h2);
    tick(40);
    chk("lineTxOe", lineTxOe, 2'h3);
    axw(4'h8, 32'h1, 2'h0);
    tick(2);
    chk("irq", irq, 1'b0);
    rchk(4'h8, 32'h2, 2'h0);
    keep_awake_in <= 1'b1;
    tick(250);
    chk("lineTxOe", lineTxOe, 2'h3);
    shutdown_n_in <= 1'b0;
    tick(3);
    chk("lineTxOe", lineTxOe, 2'h0);
    chk("logicRxOe", logicRxOe, 2'h0);
    chk("lineValid", lineValid, 1'b1);
    // register shutdown written while the pin still holds the device off
    axw(4'h0, 32'h0, 2'h0);
    shutdown_n_in <= 1'b1;
    tick(3);
    chk("lineTxOe", lineTxOe, 2'h0);
    chk("logicRxOe", logicRxOe, 2'h0);
    rchk(4'h0, 32'h0, 2'h0);
    give_verdict();
  end
endmodule // serial_line_auto_powerdown_test
`default_nettype wire
